// ===== hw/macp_top.sv
// Mirror axis controller top: polled bus, modes, watchdog and two axes
`timescale 1ns/1ps
module macp_top #(
   parameter logic [macp_pkg::ADDR_W-1:0] MY_ADDR = macp_pkg::OWN_ADDR,
   parameter longint INTERVAL = macp_pkg::INTERP_CYC,
   parameter longint COMM_TMO = macp_pkg::COMM_TMO_CYC,
   parameter logic [macp_pkg::ANG_W-1:0] STOW_AZ_P = macp_pkg::STOW_AZ,
   parameter logic [macp_pkg::ANG_W-1:0] STOW_EL_P = macp_pkg::STOW_EL
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_msg_valid,
   input wire logic i_msg_last,
   input wire logic [macp_pkg::ADDR_W-1:0] i_msg_addr,
   input wire macp_pkg::macp_mode_t i_msg_mode,
   input wire logic [macp_pkg::ANG_W-1:0] i_msg_az,
   input wire logic [macp_pkg::ANG_W-1:0] i_msg_el,
   input wire logic i_az_enc_inc,
   input wire logic i_az_enc_dec,
   input wire logic i_el_enc_inc,
   input wire logic i_el_enc_dec,
   output logic o_reply_valid,
   output logic [macp_pkg::ADDR_W-1:0] o_reply_addr,
   output logic [macp_pkg::ANG_W-1:0] o_reply_az,
   output logic [macp_pkg::ANG_W-1:0] o_reply_el,
   output logic [2:0] o_reply_flags,
   output macp_pkg::macp_mode_t o_mode,
   output logic o_az_step,
   output logic o_az_dir,
   output logic o_el_step,
   output logic o_el_dir
);
   import macp_pkg::*;
   typedef struct packed {
      macp_msg_t st;
      macp_mode_t mode;
      logic [63:0] wdog;
      logic lost;
      logic [ANG_W-1:0] az;
      logic [ANG_W-1:0] el;
      logic load;
      logic rvalid;
      logic [ANG_W-1:0] raz;
      logic [ANG_W-1:0] rel;
      logic [2:0] rflags;
      logic az_step;
      logic az_dir;
      logic el_step;
      logic el_dir;
   } macp_top_t;
   macp_top_t s_q, s_d;
   macp_axis_if #(.ANG_W(ANG_W)) az_if ();
   macp_axis_if #(.ANG_W(ANG_W)) el_if ();
   // ==========================================
   // Axis wiring
   assign az_if.load = s_q.load;
   assign az_if.target = s_q.az;
   assign az_if.enc_inc = i_az_enc_inc;
   assign az_if.enc_dec = i_az_enc_dec;
   assign el_if.load = s_q.load;
   assign el_if.target = s_q.el;
   assign el_if.enc_inc = i_el_enc_inc;
   assign el_if.enc_dec = i_el_enc_dec;
   macp_axis #(.ANG_W(ANG_W), .INTERVAL(INTERVAL)) u_az (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .ax(az_if.axis)
   );
   macp_axis #(.ANG_W(ANG_W), .INTERVAL(INTERVAL)) u_el (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .ax(el_if.axis)
   );
   // ==========================================
   // Message handling, watchdog and modes
   always_comb begin
      s_d = s_q;
      s_d.load = 1'b0;
      s_d.rvalid = 1'b0;
      s_d.wdog = s_q.wdog + 64'h0000_0000_0000_0001;
      if (i_msg_valid) begin
         s_d.wdog = 64'h0000_0000_0000_0000;
      end
      unique case (s_q.st)
         MACP_IDLE: begin
            // Any address of 0..127 plus manual units fits 8 bits
            if (i_msg_valid && i_msg_addr == MY_ADDR) begin
               s_d.st = i_msg_last ? MACP_REPLY : MACP_RECV;
               s_d.mode = i_msg_mode;
               s_d.az = i_msg_az;
               s_d.el = i_msg_el;
            end
         end
         MACP_RECV: begin
            if (i_msg_valid && i_msg_last) begin
               s_d.st = MACP_REPLY;
            end
         end
         MACP_REPLY: begin
            s_d.st = MACP_IDLE;
            s_d.rvalid = 1'b1;
            s_d.raz = az_if.actual;
            s_d.rel = el_if.actual;
            s_d.rflags = {s_q.lost, el_if.fault, az_if.fault};
            s_d.lost = 1'b0;
            s_d.load = 1'b1;
         end
         default: begin
            s_d.st = MACP_IDLE;
         end
      endcase
      // Watchdog expiry; a message restarts the count, the set beats a reply clear
      if (s_q.wdog >= 64'(COMM_TMO) - 64'h0000_0000_0000_0001) begin
         s_d.lost = 1'b1;
         if (!i_msg_valid) begin
            s_d.wdog = s_q.wdog;
         end
      end
      // Shutdown drives to stow
      if (s_d.lost) begin
         s_d.mode = MACP_SHUTDOWN;
      end
      if (s_d.mode == MACP_SHUTDOWN && s_q.st != MACP_REPLY) begin
         s_d.load = (s_q.az != STOW_AZ_P) || (s_q.el != STOW_EL_P) || s_d.lost && !s_q.lost;
         s_d.az = STOW_AZ_P;
         s_d.el = STOW_EL_P;
      end
      s_d.az_step = az_if.step;
      s_d.az_dir = az_if.dir;
      s_d.el_step = el_if.step;
      s_d.el_dir = el_if.dir;
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign o_reply_valid = s_q.rvalid;
   assign o_reply_addr = MY_ADDR;
   assign o_reply_az = s_q.raz;
   assign o_reply_el = s_q.rel;
   assign o_reply_flags = s_q.rflags;
   assign o_mode = s_q.mode;
   assign o_az_step = s_q.az_step;
   assign o_az_dir = s_q.az_dir;
   assign o_el_step = s_q.el_step;
   assign o_el_dir = s_q.el_dir;
endmodule

// ===== hw/macp_pkg.sv
// Package of constants and types for the mirror axis controller
package macp_pkg;
   // Steps per revolution and encoder counts per revolution (360 / 0.36)
   localparam int STEPS_PER_REV = 200;
   localparam int ENC_PER_REV = 1000;
   // Address space
   localparam int ADDR_W = 8;
   localparam int ANG_W = 16;
   // Interpolation interval
   localparam int CLK_HZ = 200_000_000;
   localparam int INTERP_S = 5;
   localparam longint INTERP_CYC = longint'(INTERP_S) * longint'(CLK_HZ);
   // Communication loss timeout, default in milliseconds
   localparam int COMM_TMO_MS = 10_000;
   localparam longint COMM_TMO_CYC = longint'(COMM_TMO_MS) * longint'(CLK_HZ / 1000);
   localparam logic [ANG_W-1:0] STOW_AZ = 16'h0000;
   localparam logic [ANG_W-1:0] STOW_EL = 16'h0000;
   localparam logic [ADDR_W-1:0] OWN_ADDR = 8'h01;
   // Operating modes
   typedef enum logic [2:0] {
      MACP_SHUTDOWN, MACP_STANDBY, MACP_TRACK, MACP_ALIGN, MACP_MANUAL
   } macp_mode_t;
   // Message states
   typedef enum logic [1:0] {MACP_IDLE, MACP_RECV, MACP_REPLY} macp_msg_t;
endpackage

// ===== hw/macp_axis_if.sv
// Interface between the top and one axis stepper
`timescale 1ns/1ps
interface macp_axis_if #(parameter int ANG_W = 16);
   logic load;
   logic signed [ANG_W-1:0] target;
   logic enc_inc;
   logic enc_dec;
   logic signed [ANG_W-1:0] actual;
   logic step;
   logic dir;
   logic fault;
   modport top (output load, target, enc_inc, enc_dec, input actual, step, dir, fault);
   modport axis (input load, target, enc_inc, enc_dec, output actual, step, dir, fault);
endinterface

// ===== hw/macp_axis.sv
// One gimbal axis: encoder tracking and even step interpolation
`timescale 1ns/1ps
module macp_axis #(
   parameter int ANG_W = 16,
   parameter longint INTERVAL = 1_000_000_000,
   parameter int FAULT_LIM = 50
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   macp_axis_if.axis ax
);
   import macp_pkg::*;
   typedef struct packed {
      logic signed [ANG_W-1:0] tgt;
      logic signed [ANG_W-1:0] pos;
      logic signed [ANG_W+1:0] err;
      logic [ANG_W+1:0] remain;
      logic [63:0] acc;
      logic [63:0] span;
      logic step;
      logic dir;
      logic fault;
   } macp_ax_t;
   macp_ax_t s_q, s_d;
   logic signed [ANG_W+1:0] diff;
   logic signed [ANG_W+1:0] steps_need;
   logic [ANG_W+1:0] mag;
   always_comb begin
      s_d = s_q;
      s_d.step = 1'b0;
      // Encoder accumulation, 0.36 degree per count
      if (ax.enc_inc && !ax.enc_dec) begin
         s_d.pos = s_q.pos + ANG_W'(1);
      end else if (ax.enc_dec && !ax.enc_inc) begin
         s_d.pos = s_q.pos - ANG_W'(1);
      end
      if (ax.load) begin
         s_d.tgt = ax.target;
      end
      // Error in encoder counts converted to motor steps
      diff = (ANG_W+2)'(s_d.tgt) - (ANG_W+2)'(s_d.pos);
      steps_need = (ANG_W+2)'((64'(signed'(diff)) * STEPS_PER_REV) / ENC_PER_REV);
      mag = steps_need[ANG_W+1] ? (ANG_W+2)'(-steps_need) : steps_need;
      s_d.err = diff;
      if (ax.load) begin
         s_d.remain = mag;
         s_d.acc = 64'h0000_0000_0000_0000;
         s_d.span = 64'(INTERVAL);
         s_d.dir = !steps_need[ANG_W+1];
      end else if (s_q.span != 64'h0000_0000_0000_0000) begin
         // Bresenham spread of steps across the interval
         s_d.span = s_q.span - 64'h0000_0000_0000_0001;
         if (s_q.acc + 64'(s_q.remain) >= s_q.span && s_q.remain != '0) begin
            s_d.step = 1'b1;
            s_d.remain = s_q.remain - 1'b1;
            s_d.acc = s_q.acc + 64'(s_q.remain) - s_q.span;
         end else begin
            s_d.acc = s_q.acc + 64'(s_q.remain);
         end
      end else if (mag != '0) begin
         // Closed-loop correction after the interval ends
         s_d.remain = mag;
         s_d.acc = 64'h0000_0000_0000_0000;
         s_d.span = 64'(INTERVAL);
         s_d.dir = !steps_need[ANG_W+1];
      end
      // Residual judged only when no new target arrives
      s_d.fault = s_q.fault || (!ax.load && s_q.span == 64'h0000_0000_0000_0000 &&
         (mag > (ANG_W+2)'(FAULT_LIM)));
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign ax.actual = s_q.pos;
   assign ax.step = s_q.step;
   assign ax.dir = s_q.dir;
   assign ax.fault = s_q.fault;
endmodule

// ===== bench/macp_top_chk.sv
// Port checker of the mirror axis controller
`timescale 1ns/1ps
module macp_top_chk #(
   parameter logic [macp_pkg::ADDR_W-1:0] MY_ADDR = macp_pkg::OWN_ADDR,
   parameter longint COMM_TMO = 500
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_msg_valid,
   input wire logic i_msg_last,
   input wire logic [macp_pkg::ADDR_W-1:0] i_msg_addr,
   input wire logic o_reply_valid,
   input wire logic [macp_pkg::ADDR_W-1:0] o_reply_addr,
   input wire macp_pkg::macp_mode_t o_mode,
   input wire logic o_az_step,
   input wire logic o_el_step
);
   import macp_pkg::*;
   // ==========
   // Gap counter and properties
   longint gap_q;
   always_ff @(posedge i_ref_clk) gap_q <= (i_rst || i_msg_valid) ? 64'h0 : gap_q + 64'h1;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence s_own_poll;
      i_msg_valid && i_msg_last && i_msg_addr == MY_ADDR;
   endsequence
   sequence s_other_poll;
      i_msg_valid && i_msg_last && i_msg_addr != MY_ADDR;
   endsequence
   a_reply_after_poll: assert property (s_own_poll |-> ##2 o_reply_valid)
      else $error("no reply to own poll");
   a_no_foreign_reply: assert property (s_other_poll |-> ##2 !o_reply_valid)
      else $error("reply to foreign poll");
   a_reply_has_cause: assert property (o_reply_valid |-> $past(i_msg_valid, 2))
      else $error("reply without poll");
   a_reply_own_addr: assert property (o_reply_valid |-> o_reply_addr == MY_ADDR)
      else $error("reply address wrong");
   a_reply_one_pulse: assert property (o_reply_valid |=> !o_reply_valid)
      else $error("reply pulse too long");
   a_az_step_pulse: assert property (o_az_step |=> !o_az_step)
      else $error("azimuth step too long");
   a_el_step_pulse: assert property (o_el_step |=> !o_el_step)
      else $error("elevation step too long");
   a_link_loss_stop: assert property (gap_q > COMM_TMO + 4 |-> o_mode == MACP_SHUTDOWN)
      else $error("no shutdown on silence");
   a_reset_stow_mode: assert property ($fell(i_rst) |-> o_mode == MACP_SHUTDOWN)
      else $error("mode after reset wrong");
endmodule
bind macp_top macp_top_chk #(.MY_ADDR(MY_ADDR), .COMM_TMO(COMM_TMO)) u_macp_top_chk (
   .i_ref_clk, .i_rst, .i_msg_valid, .i_msg_last, .i_msg_addr, .o_reply_valid,
   .o_reply_addr, .o_mode, .o_az_step, .o_el_step);

// ===== bench/macp_field_model.sv
// Field controller model polling the controller on its bus
`timescale 1ns/1ps
module macp_field_model (
   input wire logic i_ref_clk,
   output logic o_valid,
   output logic o_last,
   output logic [macp_pkg::ADDR_W-1:0] o_addr,
   output macp_pkg::macp_mode_t o_mode,
   output logic [macp_pkg::ANG_W-1:0] o_az,
   output logic [macp_pkg::ANG_W-1:0] o_el
);
   import macp_pkg::*;
   // ==========
   // Bus master
   initial begin
      {o_valid, o_last, o_addr, o_az, o_el} = '0;
      o_mode = MACP_SHUTDOWN;
   end
   // Single-word message, fields inverted once released
   task automatic send(input logic [ADDR_W-1:0] a, input macp_mode_t m,
      input logic [ANG_W-1:0] z, e);
      @(posedge i_ref_clk);
      {o_valid, o_last, o_addr, o_az, o_el} <= {2'b11, a, z, e};
      o_mode <= m;
      @(posedge i_ref_clk);
      {o_valid, o_last, o_addr, o_az, o_el} <= {2'b00, ~a, ~z, ~e};
      o_mode <= macp_mode_t'(~m);
   endtask
endmodule

// ===== bench/macp_top_bench.sv
// Testbench of the mirror axis controller
`timescale 1ns/1ps
module macp_top_bench;
   import macp_pkg::*;
   localparam longint IVL = 1000;
   localparam longint TMO = 500;
   logic clk = 0, rst = 1, ai = 0, ad = 0, ei = 0, ed = 0;
   logic v, l, rv, as, adr, es, edr;
   logic [7:0] a, ra;
   logic [15:0] az, el, raz, rel;
   logic [2:0] rf;
   macp_mode_t m, om;
   int err_total = 0, cmp_count = 0, ap = 0, ep = 0, an = 0, en = 0;
   initial forever #2.5 clk = ~clk;
   macp_field_model u_macp_field_model (.i_ref_clk(clk), .o_valid(v), .o_last(l),
      .o_addr(a), .o_mode(m), .o_az(az), .o_el(el));
   macp_top #(.INTERVAL(IVL), .COMM_TMO(TMO)) u_macp_top (.i_ref_clk(clk), .i_rst(rst),
      .i_msg_valid(v), .i_msg_last(l), .i_msg_addr(a), .i_msg_mode(m), .i_msg_az(az),
      .i_msg_el(el), .i_az_enc_inc(ai), .i_az_enc_dec(ad), .i_el_enc_inc(ei),
      .i_el_enc_dec(ed), .o_reply_valid(rv), .o_reply_addr(ra), .o_reply_az(raz),
      .o_reply_el(rel), .o_reply_flags(rf), .o_mode(om), .o_az_step(as), .o_az_dir(adr),
      .o_el_step(es), .o_el_dir(edr));
   // ==========
   // Motor and encoder: five counts per step
   always @(posedge clk) begin
      ap = ap + (as ? (adr ? 5 : -5) : 0);
      ep = ep + (es ? (edr ? 5 : -5) : 0);
      an = an + (as ? (adr ? 1 : -1) : 0);
      en = en + (es ? (edr ? 1 : -1) : 0);
      ai <= ap > 0;
      ad <= ap < 0;
      ei <= ep > 0;
      ed <= ep < 0;
      ap = ap - (ap > 0) + (ap < 0);
      ep = ep - (ep > 0) + (ep < 0);
   end
   task automatic chk(input string n, input logic [15:0] s, e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic poll(input logic [7:0] pa, input macp_mode_t pm, input logic [15:0] pz, pe,
      input logic px);
      u_macp_field_model.send(pa, pm, pz, pe);
      @(posedge clk);
      #1 chk("reply_valid", rv, px);
      if (px) chk("reply_addr", ra, 16'h0001);
      repeat (3) @(posedge clk);
   endtask
   // Keeps the link alive with foreign polls
   task automatic pass(input int k);
      repeat (k) begin
         repeat (95) @(posedge clk);
         poll(8'h02, MACP_ALIGN, 16'h0000, 16'h0000, 1'b0);
      end
   endtask
   // ==========
   // Scenarios
   task automatic t_track;
      poll(8'h01, MACP_TRACK, 16'h0032, 16'h0019, 1'b1);
      chk("mode", om, MACP_TRACK);
      pass(5);
      chk("az spread", 16'((an > 0) && (an < 10)), 16'h0001);
      pass(6);
      chk("az steps", 16'(an), 16'h000A);
      chk("el steps", 16'(en), 16'h0005);
      poll(8'h01, MACP_TRACK, 16'h0032, 16'h0019, 1'b1);
      chk("az actual", raz, 16'h0032);
      chk("el actual", rel, 16'h0019);
      chk("flags", rf, 16'h0000);
      $display("track test done");
   endtask
   task automatic t_modes;
      logic [7:0] fa [3] = '{8'h00, 8'h7F, 8'h80};
      foreach (fa[j]) poll(fa[j], MACP_ALIGN, 16'h0000, 16'h0000, 1'b0);
      chk("mode kept", om, MACP_TRACK);
      for (int i = 0; i < 5; i++) begin
         poll(8'h01, macp_mode_t'(i), 16'h0032, 16'h0019, 1'b1);
         chk("mode", om, macp_mode_t'(i));
      end
      $display("mode test done");
   endtask
   // Encoder slip of ten counts, healed by the closed loop
   task automatic t_slip;
      int a0;
      #1 a0 = an;
      ap = ap - 10;
      pass(21);
      poll(8'h01, MACP_MANUAL, 16'h0032, 16'h0019, 1'b1);
      chk("az fix steps", 16'(an - a0), 16'h0002);
      chk("az healed", raz, 16'h0032);
      chk("fix flags", rf, 16'h0000);
      $display("slip test done");
   endtask
   task automatic t_loss;
      repeat (TMO + 20) @(posedge clk);
      chk("loss mode", om, MACP_SHUTDOWN);
      repeat (IVL + 50) @(posedge clk);
      poll(8'h01, MACP_SHUTDOWN, 16'h0032, 16'h0019, 1'b1);
      chk("stow az", raz, 16'h0000);
      chk("lost flag", rf, 16'h0004);
      poll(8'h01, MACP_SHUTDOWN, 16'h0032, 16'h0019, 1'b1);
      chk("flag clear", rf, 16'h0000);
      $display("loss test done");
   endtask
   initial begin
      #(40 * IVL * 5);
      err_total++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 chk("reset mode", om, MACP_SHUTDOWN);
      chk("reset reply", rv, 16'h0000);
      t_track;
      t_modes;
      t_slip;
      t_loss;
      wrap_up;
   end
endmodule
